// ### rtl/qbp_regs.svh
// Constants for the quasi-bidirectional port bit logic.
`ifndef QBP_REGS_SVH
`define QBP_REGS_SVH

// Oscillator periods in one machine cycle: six states of two phases.
`define QBP_OSC_PER_CYCLE 12
// Value loaded into every port latch by reset.
`define QBP_LATCH_RESET 8'hFF
// Value forced into the port zero latch during external accesses.
`define QBP_EXT_FILL 8'hFF
// Boost pullup on-time in oscillator periods after a latch rise.
`define QBP_BOOST_OSC_PERIODS 2
// One clk edge is one oscillator period, so the count equals the time.
`define QBP_BOOST_CYCLES (`QBP_BOOST_OSC_PERIODS * 1)
// Port indices inside the arrays.
`define QBP_PORT0 0
`define QBP_PORT1 1
`define QBP_PORT2 2
`define QBP_PORT3 3

`endif

// ### rtl/qbp_pkg.sv
// Types shared by the port bit logic modules.
package qbp_pkg;

  // Machine-cycle state, each split into phase one and phase two.
  typedef enum logic [2:0] {
    QBP_ST1,
    QBP_ST2,
    QBP_ST3,
    QBP_ST4,
    QBP_ST5,
    QBP_ST6
  } qbp_state_e;

  typedef logic [7:0] qbp_byte_t;

endpackage

// ### rtl/qbp_cycle_timer.sv
// Machine-cycle state and phase sequencer for the port bit logic.
`timescale 1ns/100ps
`default_nettype none

module qbp_cycle_timer (
  input wire logic clk,
  input wire logic arst_n,
  output logic phase_one,
  output logic state_one_phase_one,
  output logic state_one_phase_two,
  output logic state_six_phase_two
);

  qbp_pkg::qbp_state_e state;
  qbp_pkg::qbp_state_e next_state;
  logic phase_two;
  logic next_phase_two;

  // Each clk edge is one oscillator period; phase two ends a state.
  always_comb begin
    next_phase_two = ~phase_two;
    next_state = state;
    if (phase_two) begin
      case (state)
        qbp_pkg::QBP_ST1: next_state = qbp_pkg::QBP_ST2;
        qbp_pkg::QBP_ST2: next_state = qbp_pkg::QBP_ST3;
        qbp_pkg::QBP_ST3: next_state = qbp_pkg::QBP_ST4;
        qbp_pkg::QBP_ST4: next_state = qbp_pkg::QBP_ST5;
        qbp_pkg::QBP_ST5: next_state = qbp_pkg::QBP_ST6;
        qbp_pkg::QBP_ST6: next_state = qbp_pkg::QBP_ST1;
        default: next_state = qbp_pkg::QBP_ST1;
      endcase
    end
  end

  // Reset starts the sequence at the first phase of state one.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= qbp_pkg::QBP_ST1;
      phase_two <= 1'b0;
    end else begin
      state <= next_state;
      phase_two <= next_phase_two;
    end
  end

  // Decoded phase markers, each high for one oscillator period.
  assign phase_one = ~phase_two;
  assign state_one_phase_one = (state == qbp_pkg::QBP_ST1) & ~phase_two;
  assign state_one_phase_two = (state == qbp_pkg::QBP_ST1) & phase_two;
  assign state_six_phase_two = (state == qbp_pkg::QBP_ST6) & phase_two;

endmodule

`default_nettype wire

// ### rtl/qbp_ports.sv
// Bit latches, read paths and pin drivers of four 8-bit I/O ports.
`timescale 1ns/100ps
`default_nettype none
`include "qbp_regs.svh"

module qbp_ports #(
  parameter int WIDTH = 8,
  parameter int NPORTS = 4
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [3:0] wr_latch,
  input wire logic [7:0] wr_data,
  input wire logic [3:0] bit_wr,
  input wire logic [2:0] bit_idx,
  input wire logic bit_val,
  input wire logic [3:0] rd_latch,
  input wire logic [3:0] rd_pin,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic state_six_phase_two,
  input wire logic ext_active,
  input wire logic ext_addr16,
  input wire logic [7:0] addr_hi,
  input wire logic [7:0] ad_out,
  input wire logic ad_drive,
  output logic [7:0] ad_in,
  input wire logic [7:0] alt_out,
  output logic [7:0] alt_in,
  input wire logic [7:0] port0_pin_in,
  output logic [7:0] port0_pin_out,
  output logic [7:0] port0_pin_oe,
  input wire logic [7:0] port1_pin_in,
  output logic [7:0] port1_pin_out,
  output logic [7:0] port1_pin_oe,
  output logic [7:0] port1_keeper_pullup,
  output logic [7:0] port1_hold_pullup,
  input wire logic [7:0] port2_pin_in,
  output logic [7:0] port2_pin_out,
  output logic [7:0] port2_pin_oe,
  output logic [7:0] port2_keeper_pullup,
  output logic [7:0] port2_hold_pullup,
  input wire logic [7:0] port3_pin_in,
  output logic [7:0] port3_pin_out,
  output logic [7:0] port3_pin_oe,
  output logic [7:0] port3_keeper_pullup,
  output logic [7:0] port3_hold_pullup
);

  logic phase_one;
  logic state_one_phase_one;
  logic state_one_phase_two;

  // Machine-cycle sequencer gives the phase enables.
  qbp_cycle_timer u_timer (
    .clk(clk),
    .arst_n(arst_n),
    .phase_one(phase_one),
    .state_one_phase_one(state_one_phase_one),
    .state_one_phase_two(state_one_phase_two),
    .state_six_phase_two(state_six_phase_two)
  );

  // Replace one bit of a byte, as the bit operations do.
  function automatic logic [WIDTH-1:0] set_bit(
    input logic [WIDTH-1:0] value,
    input logic [2:0] idx,
    input logic bv
  );
    logic [WIDTH-1:0] res;
    res = value;
    res[idx] = bv;
    return res;
  endfunction

  logic [WIDTH-1:0] pin_in [NPORTS];
  assign pin_in[`QBP_PORT0] = port0_pin_in;
  assign pin_in[`QBP_PORT1] = port1_pin_in;
  assign pin_in[`QBP_PORT2] = port2_pin_in;
  assign pin_in[`QBP_PORT3] = port3_pin_in;

  // Latch state: the latch itself, a staged value and its pending flag.
  logic [WIDTH-1:0] port_latch [NPORTS];
  logic [WIDTH-1:0] next_port_latch [NPORTS];
  logic [WIDTH-1:0] staged [NPORTS];
  logic [WIDTH-1:0] next_staged [NPORTS];
  logic [NPORTS-1:0] pend;
  logic [NPORTS-1:0] next_pend;

  // Writes are staged and only land at state six phase two, so a port
  // write never changes a pin in the middle of a machine cycle.
  always_comb begin
    for (int p = 0; p < NPORTS; p++) begin
      next_staged[p] = staged[p];
      next_pend[p] = pend[p];
      next_port_latch[p] = port_latch[p];
      if (wr_latch[p]) begin
        next_staged[p] = wr_data;
        next_pend[p] = 1'b1;
      end
      if (bit_wr[p]) begin
        // Modify the newest byte, taken from the latch side.
        next_staged[p] = set_bit(pend[p] ? staged[p] : port_latch[p],
                                 bit_idx, bit_val);
        next_pend[p] = 1'b1;
      end
      if (state_six_phase_two && next_pend[p]) begin
        next_port_latch[p] = next_staged[p];
        next_pend[p] = 1'b0;
      end
    end
    if (ext_active) begin
      // Port zero latch is overwritten; port two latch is left alone.
      next_port_latch[`QBP_PORT0] = `QBP_EXT_FILL;
      next_pend[`QBP_PORT0] = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int p = 0; p < NPORTS; p++) begin
        port_latch[p] <= `QBP_LATCH_RESET;
        staged[p] <= `QBP_LATCH_RESET;
      end
      pend <= '0;
    end else begin
      port_latch <= next_port_latch;
      staged <= next_staged;
      pend <= next_pend;
    end
  end

  // Output buffer copies of the latches and boost state.
  logic [WIDTH-1:0] buf_q [NPORTS];
  logic [WIDTH-1:0] next_buf_q [NPORTS];
  logic [WIDTH-1:0] rise [NPORTS];
  logic [WIDTH-1:0] next_rise [NPORTS];
  logic [1:0] boost_cnt;
  logic [1:0] next_boost_cnt;

  // Buffers take the latch only in phase one and hold it through phase
  // two. A latch rise is caught at the state one sample and drives the
  // boost for the fixed count of oscillator periods.
  always_comb begin
    next_boost_cnt = boost_cnt;
    for (int p = 0; p < NPORTS; p++) begin
      next_buf_q[p] = buf_q[p];
      next_rise[p] = rise[p];
      if (phase_one) begin
        next_buf_q[p] = port_latch[p];
      end
      if (state_one_phase_one) begin
        next_rise[p] = ~buf_q[p] & port_latch[p];
      end
    end
    if (state_one_phase_one) begin
      next_boost_cnt = 2'(`QBP_BOOST_CYCLES);
    end else if (boost_cnt != 2'h0) begin
      next_boost_cnt = boost_cnt - 2'h1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int p = 0; p < NPORTS; p++) begin
        buf_q[p] <= `QBP_LATCH_RESET;
        rise[p] <= 8'h00;
      end
      boost_cnt <= 2'h0;
    end else begin
      buf_q <= next_buf_q;
      rise <= next_rise;
      boost_cnt <= next_boost_cnt;
    end
  end

  // Level each port wants on its pins, after bus and alternate muxing.
  logic [WIDTH-1:0] eff [NPORTS];
  logic [WIDTH-1:0] boost [NPORTS];
  logic two_addr;
  logic zero_bus;

  always_comb begin
    zero_bus = ext_active;
    two_addr = ext_active & ext_addr16;
    eff[`QBP_PORT0] = zero_bus ? ad_out : buf_q[`QBP_PORT0];
    eff[`QBP_PORT1] = buf_q[`QBP_PORT1];
    eff[`QBP_PORT2] = two_addr ? addr_hi : buf_q[`QBP_PORT2];
    // Latch zero forces low; latch one hands over to the alternate.
    eff[`QBP_PORT3] = buf_q[`QBP_PORT3] & alt_out;
    for (int p = 0; p < NPORTS; p++) begin
      boost[p] = (boost_cnt != 2'h0) ? (rise[p] & eff[p]) : 8'h00;
    end
    boost[`QBP_PORT0] = 8'h00;
  end

  // Registered pin drive. The hold pullup latches the one through the
  // pin feedback, so an external low or a pulldown drops it.
  logic [WIDTH-1:0] pin_out [NPORTS];
  logic [WIDTH-1:0] next_pin_out [NPORTS];
  logic [WIDTH-1:0] pin_oe [NPORTS];
  logic [WIDTH-1:0] next_pin_oe [NPORTS];
  logic [WIDTH-1:0] keeper [NPORTS];
  logic [WIDTH-1:0] next_keeper [NPORTS];
  logic [WIDTH-1:0] hold [NPORTS];
  logic [WIDTH-1:0] next_hold [NPORTS];

  always_comb begin
    for (int p = 0; p < NPORTS; p++) begin
      next_pin_out[p] = eff[p];
      // Strong drive: pulldown for zeros, boost for a rising one.
      next_pin_oe[p] = ~eff[p] | boost[p];
      next_keeper[p] = eff[p];
      next_hold[p] = (hold[p] | boost[p]) & eff[p] & pin_in[p];
    end
    if (two_addr) begin
      next_pin_oe[`QBP_PORT2] = 8'hFF;
    end
    // Port zero is open drain unless it carries the external bus.
    next_keeper[`QBP_PORT0] = 8'h00;
    next_hold[`QBP_PORT0] = 8'h00;
    if (zero_bus) begin
      next_pin_oe[`QBP_PORT0] = ad_drive ? 8'hFF : 8'h00;
    end else begin
      next_pin_oe[`QBP_PORT0] = ~buf_q[`QBP_PORT0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int p = 0; p < NPORTS; p++) begin
        pin_out[p] <= `QBP_LATCH_RESET;
        pin_oe[p] <= 8'h00;
        keeper[p] <= 8'h00;
        hold[p] <= 8'h00;
      end
    end else begin
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
      keeper <= next_keeper;
      hold <= next_hold;
    end
  end

  assign port0_pin_out = pin_out[`QBP_PORT0];
  assign port0_pin_oe = pin_oe[`QBP_PORT0];
  assign port1_pin_out = pin_out[`QBP_PORT1];
  assign port1_pin_oe = pin_oe[`QBP_PORT1];
  assign port1_keeper_pullup = keeper[`QBP_PORT1];
  assign port1_hold_pullup = hold[`QBP_PORT1];
  assign port2_pin_out = pin_out[`QBP_PORT2];
  assign port2_pin_oe = pin_oe[`QBP_PORT2];
  assign port2_keeper_pullup = keeper[`QBP_PORT2];
  assign port2_hold_pullup = hold[`QBP_PORT2];
  assign port3_pin_out = pin_out[`QBP_PORT3];
  assign port3_pin_oe = pin_oe[`QBP_PORT3];
  assign port3_keeper_pullup = keeper[`QBP_PORT3];
  assign port3_hold_pullup = hold[`QBP_PORT3];

  // Pins pass straight to the alternate inputs and the bus data input;
  // the latch state plays no part in them.
  assign alt_in = port3_pin_in;
  assign ad_in = port0_pin_in;

  // Read paths. The lowest numbered strobe wins if several are raised.
  logic [WIDTH-1:0] next_rd_data;
  logic next_rd_valid;

  always_comb begin
    next_rd_data = rd_data;
    next_rd_valid = 1'b0;
    for (int p = NPORTS - 1; p >= 0; p--) begin
      if (rd_latch[p]) begin
        next_rd_data = port_latch[p];
        next_rd_valid = 1'b1;
      end else if (rd_pin[p]) begin
        next_rd_data = pin_in[p];
        next_rd_valid = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_data <= next_rd_data;
      rd_valid <= next_rd_valid;
    end
  end

endmodule

`default_nettype wire

// ### verif/qbp_pin_load.sv
// Model of the external circuitry that loads one 8-bit port.
`timescale 1ns/100ps
`default_nettype none

module qbp_pin_load (
  input wire logic clk,
  input wire logic [7:0] out,
  input wire logic [7:0] oe,
  input wire logic [7:0] pull,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pin
);
  logic [7:0] flip = 8'h55;

  // A floating line has no defined level, so it shows a changing pattern.
  always @(posedge clk) begin
    flip <= ~flip;
  end

  // Strong drive wins, then the outside source, then the weak pullup.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin[i] = oe[i] ? out[i] : ext_en[i] ? ext_val[i] :
        pull[i] ? 1'b1 : flip[i];
    end
  end
endmodule
`default_nettype wire

// ### verif/qbp_ports_checker.sv
// Concurrent checks on the ports of the port bit logic.
`timescale 1ns/100ps
`default_nettype none

module qbp_ports_checker (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [3:0] rd_latch,
  input wire logic [3:0] rd_pin,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  input wire logic state_six_phase_two,
  input wire logic ext_active,
  input wire logic ext_addr16,
  input wire logic ad_drive,
  input wire logic [7:0] addr_hi,
  input wire logic [7:0] ad_out,
  input wire logic [7:0] alt_in,
  input wire logic [7:0] ad_in,
  input wire logic [7:0] port0_pin_in,
  input wire logic [7:0] port1_pin_in,
  input wire logic [7:0] port3_pin_in,
  input wire logic [7:0] port0_pin_out,
  input wire logic [7:0] port0_pin_oe,
  input wire logic [7:0] port1_pin_out,
  input wire logic [7:0] port1_pin_oe,
  input wire logic [7:0] port1_keeper_pullup,
  input wire logic [7:0] port1_hold_pullup,
  input wire logic [7:0] port2_pin_out,
  input wire logic [7:0] port2_pin_oe
);
  // One clock domain, so clocking and reset are given once.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_rd_ack; (|rd_latch || |rd_pin) |=> rd_valid; endproperty
  a_rd_ack: assert property (p_rd_ack) else $error("read lost");
  property p_rd_quiet; !(|rd_latch || |rd_pin) |=> !rd_valid; endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("stray read");
  property p_pin_rd;
    rd_pin == 4'h2 && rd_latch == 4'h0 |=> rd_data == $past(port1_pin_in);
  endproperty
  a_pin_rd: assert property (p_pin_rd) else $error("pin read bad");
  // The commit slot recurs once per machine cycle of 12 periods.
  property p_period;
    state_six_phase_two |=> !state_six_phase_two [*8] ##3
      !state_six_phase_two ##1 state_six_phase_two;
  endproperty
  a_period: assert property (p_period) else $error("slot period");
  property p_alt_in; alt_in == port3_pin_in; endproperty
  a_alt_in: assert property (p_alt_in) else $error("alt input");
  // The bus data input must follow the pins whatever the latch holds.
  property p_ad_in; ad_in == port0_pin_in; endproperty
  a_ad_in: assert property (p_ad_in) else $error("bus data input");
  property p_ext0;
    ext_active && ad_drive |=>
      port0_pin_out == $past(ad_out) && port0_pin_oe == 8'hFF;
  endproperty
  a_ext0: assert property (p_ext0) else $error("port zero bus");
  property p_ext2;
    ext_active && ext_addr16 |=>
      port2_pin_out == $past(addr_hi) && port2_pin_oe == 8'hFF;
  endproperty
  a_ext2: assert property (p_ext2) else $error("port two bus");
  property p_open;
    $past(arst_n) && !$past(ext_active) |->
      (port0_pin_oe & port0_pin_out) == 8'h00;
  endproperty
  a_open: assert property (p_open) else $error("port zero pullup");
  property p_keeper;
    $past(arst_n) |->
      port1_keeper_pullup == ~(port1_pin_oe & ~port1_pin_out);
  endproperty
  a_keeper: assert property (p_keeper) else $error("keeper");
  property p_hold;
    $past(arst_n) |-> (port1_hold_pullup & ~$past(port1_pin_in)) == 8'h00;
  endproperty
  a_hold: assert property (p_hold) else $error("hold on low pin");
endmodule

bind qbp_ports qbp_ports_checker u_chk (.*);
`default_nettype wire

// ### verif/qbp_ports_tb.sv
// Self-checking bench for the port bit logic with external loads.
`timescale 1ns/100ps
`default_nettype none

module qbp_ports_tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] wr_latch = 4'h0, bit_wr = 4'h0, rd_latch = 4'h0, rd_pin = 4'h0;
  logic [7:0] wr_data = 8'h00, addr_hi = 8'h00, ad_out = 8'h00;
  logic [7:0] alt_out = 8'h00;
  logic [2:0] bit_idx = 3'h0;
  logic bit_val = 1'b0, ext_active = 1'b0, ext_addr16 = 1'b0, ad_drive = 1'b0;
  logic [7:0] ext_en [4] = '{default: 8'h00};
  logic [7:0] ext_val [4] = '{default: 8'h00};
  logic [7:0] rd_data, pin_in [4], pin_out [4], pin_oe [4], keep [4], hold [4];
  logic rd_valid, commit_slot;
  logic [7:0] m [4];
  int seed = 50, err_total = 0, tests_run = 0, cycles = 0;

  always #2 clk = ~clk;

  qbp_ports DUT (.clk(clk), .arst_n(arst_n), .wr_latch(wr_latch),
    .wr_data(wr_data), .bit_wr(bit_wr), .bit_idx(bit_idx), .bit_val(bit_val),
    .rd_latch(rd_latch), .rd_pin(rd_pin), .rd_data(rd_data),
    .rd_valid(rd_valid), .state_six_phase_two(commit_slot),
    .ext_active(ext_active), .ext_addr16(ext_addr16), .addr_hi(addr_hi),
    .ad_out(ad_out), .ad_drive(ad_drive), .ad_in(), .alt_out(alt_out),
    .alt_in(), .port0_pin_in(pin_in[0]), .port0_pin_out(pin_out[0]),
    .port0_pin_oe(pin_oe[0]), .port1_pin_in(pin_in[1]),
    .port1_pin_out(pin_out[1]), .port1_pin_oe(pin_oe[1]),
    .port1_keeper_pullup(keep[1]), .port1_hold_pullup(hold[1]),
    .port2_pin_in(pin_in[2]), .port2_pin_out(pin_out[2]),
    .port2_pin_oe(pin_oe[2]), .port2_keeper_pullup(keep[2]),
    .port2_hold_pullup(hold[2]), .port3_pin_in(pin_in[3]),
    .port3_pin_out(pin_out[3]), .port3_pin_oe(pin_oe[3]),
    .port3_keeper_pullup(keep[3]), .port3_hold_pullup(hold[3]));

  // Port zero has no internal pullup, so its load sees none.
  for (genvar g = 0; g < 4; g++) begin : g_ld
    qbp_pin_load u_ld (.clk(clk), .out(pin_out[g]), .oe(pin_oe[g]),
      .pull(g == 0 ? 8'h00 : keep[g]), .ext_en(ext_en[g]),
      .ext_val(ext_val[g]), .pin(pin_in[g]));
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // A hang would otherwise never reach the verdict.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end

  function automatic logic [7:0] exp_pin(input int p, input logic [7:0] v);
    return p == 3 ? v & alt_out : v;
  endfunction

  // Returns at the edge where the latch takes staged values.
  task automatic wait_commit();
    do @(negedge clk); while (commit_slot !== 1'b1);
    @(posedge clk);
  endtask

  task automatic rd(input bit pin, input int p, output logic [7:0] d);
    @(posedge clk);
    rd_pin <= pin ? 4'(1 << p) : 4'h0;
    rd_latch <= pin ? 4'h0 : 4'(1 << p);
    @(posedge clk);
    rd_pin <= 4'h0;
    rd_latch <= 4'h0;
    @(negedge clk);
    check({7'h00, rd_valid}, 8'h01);
    d = rd_data;
  endtask

  // The write is made just after a commit, so the old value must persist.
  task automatic wr(input int p, input bit bop, input logic [7:0] d,
    input logic [2:0] i, input logic v);
    logic [7:0] r;
    logic [7:0] old;
    logic [7:0] en;
    old = m[p];
    m[p] = bop ? ((old & ~(8'h01 << i)) | ({7'h00, v} << i)) : d;
    wait_commit();
    wr_latch <= bop ? 4'h0 : 4'(1 << p);
    bit_wr <= bop ? 4'(1 << p) : 4'h0;
    wr_data <= d;
    bit_idx <= i;
    bit_val <= v;
    @(posedge clk);
    wr_latch <= 4'h0;
    bit_wr <= 4'h0;
    rd(0, p, r);
    check(r, old);
    wait_commit();
    repeat (2) @(negedge clk);
    check(pin_out[p], exp_pin(p, old));
    @(negedge clk);
    en = exp_pin(p, m[p]);
    check(pin_out[p], en);
    // Port zero is open drain; the others add the boost on rising ones.
    if (p == 0) check(pin_oe[p], ~en);
    else check(pin_oe[p], ~en | (~old & en));
    if (p != 0) check(keep[p], en);
    rd(0, p, r);
    check(r, m[p]);
  endtask

  initial begin
    logic [7:0] r;
    logic [7:0] e;
    logic [7:0] v;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    alt_out <= 8'($random(seed));
    for (int p = 0; p < 4; p++) begin
      m[p] = 8'hFF;
      rd(0, p, r);
      check(r, 8'hFF);
    end
    $display("reset values done");
    wr(1, 0, 8'h00, 3'h0, 1'b0);
    wr(1, 0, 8'hFF, 3'h0, 1'b0);
    check(hold[1], 8'hFF);
    for (int n = 0; n < 24; n++) begin
      wr(n % 4, n[2], 8'($random(seed)), 3'($random(seed)), n[3]);
    end
    $display("latch writes done");
    wr(1, 0, 8'hFF, 3'h0, 1'b0);
    for (int n = 0; n < 8; n++) begin
      e = 8'($random(seed));
      v = 8'($random(seed));
      @(posedge clk);
      ext_en[1] <= e;
      ext_val[1] <= v;
      rd(1, 1, r);
      check(r, (v & e) | ~e);
      rd(0, 1, r);
      check(r, 8'hFF);
    end
    ext_en[1] <= 8'h00;
    $display("pin reads done");
    for (int n = 0; n < 4; n++) begin
      @(posedge clk);
      ext_active <= 1'b1;
      ext_addr16 <= n[0];
      ad_drive <= n[1];
      ad_out <= 8'($random(seed));
      addr_hi <= 8'($random(seed));
      wr_latch <= 4'h1;
      wr_data <= 8'h00;
      @(posedge clk);
      wr_latch <= 4'h0;
      wait_commit();
      @(negedge clk);
      check(pin_out[0], ad_out);
      check(pin_oe[0], n[1] ? 8'hFF : 8'h00);
      check(pin_out[2], n[0] ? addr_hi : m[2]);
      @(posedge clk);
      ext_active <= 1'b0;
      rd(0, 0, r);
      check(r, 8'hFF);
      rd(0, 2, r);
      check(r, m[2]);
    end
    $display("external access done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
